// >>> common/sbc_consts.vh
// Register offsets, field positions, reset values and timing counts of the staged control block
`ifndef SBC_CONSTS_VH
`define SBC_CONSTS_VH

`define SBC_ADDR_EXECUTE 16'hAC46
`define SBC_ADDR_PASS_HI 16'hAC47
`define SBC_ADDR_PASS_LO 16'hAC48
`define SBC_ADDR_RSVD 16'hAC49
`define SBC_ADDR_SELECT 16'hAC4A
`define SBC_ADDR_CONFIRM 16'hAC4B

`define SBC_EXEC_VALUE 16'h0001
`define SBC_PASS_DEFAULT 16'h2020
`define SBC_WORD_RESET 16'h0000
`define SBC_SEL_MASK 16'h00FC

`define SBC_BIT_LATCH_RST 7
`define SBC_BIT_MAINT_ACK 6
`define SBC_BIT_RUNTIME_ACK 5
`define SBC_BIT_WEAR_ACK 4
`define SBC_BIT_OPEN 3
`define SBC_BIT_CLOSE 2

// 15 s at the 40 MHz system clock, sized to the watchdog counter width
`define SBC_TIMEOUT_CYCLES 30'h23C3_4600
`define SBC_WDOG_W 30

`endif

// >>> design/sbc_sync.v
// Three-stage synchroniser with agreement filter for the local/remote selector pin
`timescale 1ns/1ps
module sbc_sync (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire async_i,
  output reg level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Reset assumes local mode so nothing fires before the pin is known
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule // sbc_sync

// >>> design/sbc_wdog.v
// Watchdog counter that expires a staged configuration left without an execute
`timescale 1ns/1ps
`include "sbc_consts.vh"
module sbc_wdog #(
  parameter [`SBC_WDOG_W-1:0] CYCLES = `SBC_TIMEOUT_CYCLES
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire restart_i,
  input wire stop_i,
  output reg expire_o,
  output reg running_o
);
  reg [`SBC_WDOG_W-1:0] cnt_reg;

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= {`SBC_WDOG_W{1'b0}};
      running_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (stop_i) begin
        running_o <= 1'b0;
        cnt_reg <= {`SBC_WDOG_W{1'b0}};
      end else if (restart_i) begin
        running_o <= 1'b1;
        cnt_reg <= {`SBC_WDOG_W{1'b0}};
      end else if (running_o) begin
        if (cnt_reg == CYCLES - {{(`SBC_WDOG_W-1){1'b0}}, 1'b1}) begin
          running_o <= 1'b0;
          expire_o <= 1'b1;
          cnt_reg <= {`SBC_WDOG_W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + {{(`SBC_WDOG_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // sbc_wdog

// >>> design/sbc_top.v
// Staged breaker control block: holding register staging, execute, watchdog and command pulses
//
// Function
// - Only an execute register write of exactly 1 launches the staged command.
// - Without execute within 15 s of configuration, the block clears itself.
// - One multi-register transaction holding all registers plus execute is accepted.
// - In local mode a command is acknowledged but no action is taken.
// - Selection bit 7 resets all latched output elements on execution.
// - Bits 6, 5, 4 acknowledge maintenance, run time and wear alarms.
// - Selection bit 3 trips the motor breaker on execution.
// - Selection bit 2 closes the motor breaker on execution, unless bit 3 is also set.
`timescale 1ns/1ps
`include "sbc_consts.vh"
module sbc_top #(
  parameter [`SBC_WDOG_W-1:0] WATCHDOG_CYCLES = `SBC_TIMEOUT_CYCLES,
  parameter [15:0] PASS_HI = `SBC_PASS_DEFAULT,
  parameter [15:0] PASS_LO = `SBC_PASS_DEFAULT
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire wr_en_i,
  input wire [15:0] wr_addr_i,
  input wire [15:0] wr_data_i,
  input wire wr_last_i,
  input wire rd_en_i,
  input wire [15:0] rd_addr_i,
  input wire remote_mode_i,
  output reg [15:0] rd_data_o,
  output reg rd_valid_o,
  output reg cmd_ack_o,
  output reg cmd_reject_o,
  output reg timeout_o,
  output reg armed_o,
  output reg remote_o,
  output reg latch_reset_global_o,
  output reg maintenance_schedule_alarm_o,
  output reg runtime_alarm_o,
  output reg wear_alarm_o,
  output reg motor_breaker_object_open_o,
  output reg motor_breaker_object_close_o
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ARMED = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] pass_hi_reg;
  reg [15:0] pass_lo_reg;
  reg [15:0] select_reg;
  reg [15:0] confirm_reg;
  reg exec_pend_reg;
  reg exec_pend_next;
  reg staged_in_txn_reg;
  reg staged_in_txn_next;

  wire remote_level;
  wire wd_expire;
  wire wd_running;

  wire hit_exec = wr_en_i && (wr_addr_i == `SBC_ADDR_EXECUTE);
  wire hit_pass_hi = wr_en_i && (wr_addr_i == `SBC_ADDR_PASS_HI);
  wire hit_pass_lo = wr_en_i && (wr_addr_i == `SBC_ADDR_PASS_LO);
  wire hit_select = wr_en_i && (wr_addr_i == `SBC_ADDR_SELECT);
  wire hit_confirm = wr_en_i && (wr_addr_i == `SBC_ADDR_CONFIRM);
  wire hit_stage = hit_pass_hi || hit_pass_lo || hit_select || hit_confirm;
  wire exec_one = hit_exec && (wr_data_i == `SBC_EXEC_VALUE);

  // Execute is the lowest address, so in one ascending transaction it arrives
  // first; the decision waits for the transaction end so later words count
  // A closing execute word that is not 1 cancels an earlier 1 of the same transaction
  wire fire = wr_en_i && wr_last_i && (hit_exec ? exec_one : exec_pend_reg);
  wire txn_staged = staged_in_txn_reg || hit_stage;

  // Words written in this same cycle must be part of the check
  wire [15:0] pass_hi_eff = hit_pass_hi ? wr_data_i : pass_hi_reg;
  wire [15:0] pass_lo_eff = hit_pass_lo ? wr_data_i : pass_lo_reg;
  wire [15:0] select_eff = hit_select ? (wr_data_i & `SBC_SEL_MASK) : select_reg;
  wire [15:0] confirm_eff = hit_confirm ? (wr_data_i & `SBC_SEL_MASK) : confirm_reg;
  wire pass_ok = (pass_hi_eff == PASS_HI) && (pass_lo_eff == PASS_LO);
  wire valid_cmd = pass_ok && (select_eff == confirm_eff);
  wire act = valid_cmd && remote_level;

  // Restart timing at the end of every configuring transaction without execute
  wire wd_restart = wr_en_i && wr_last_i && txn_staged && !fire;
  wire wd_stop = fire;

  sbc_sync u_remote_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(remote_mode_i),
    .level_o(remote_level)
  );

  sbc_wdog #(
    .CYCLES(WATCHDOG_CYCLES)
  ) u_wdog (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .restart_i(wd_restart),
    .stop_i(wd_stop),
    .expire_o(wd_expire),
    .running_o(wd_running)
  );

  always @* begin
    exec_pend_next = exec_pend_reg;
    staged_in_txn_next = staged_in_txn_reg;
    if (wr_en_i) begin
      if (wr_last_i) begin
        exec_pend_next = 1'b0;
        staged_in_txn_next = 1'b0;
      end else begin
        if (hit_exec) begin
          exec_pend_next = exec_one;
        end
        if (hit_stage) begin
          staged_in_txn_next = 1'b1;
        end
      end
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wd_restart) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (fire) begin
          state_next = ST_IDLE;
        end else if (wd_restart) begin
          state_next = ST_ARMED;
        end else if (wd_expire) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      exec_pend_reg <= 1'b0;
      staged_in_txn_reg <= 1'b0;
      pass_hi_reg <= `SBC_WORD_RESET;
      pass_lo_reg <= `SBC_WORD_RESET;
      select_reg <= `SBC_WORD_RESET;
      confirm_reg <= `SBC_WORD_RESET;
    end else begin
      state_reg <= state_next;
      exec_pend_reg <= exec_pend_next;
      staged_in_txn_reg <= staged_in_txn_next;
      // A new staging write in the expiry cycle wins over the clear
      if (fire || (wd_expire && !hit_stage)) begin
        pass_hi_reg <= `SBC_WORD_RESET;
        pass_lo_reg <= `SBC_WORD_RESET;
        select_reg <= `SBC_WORD_RESET;
        confirm_reg <= `SBC_WORD_RESET;
      end else begin
        if (hit_pass_hi) begin
          pass_hi_reg <= wr_data_i;
        end
        if (hit_pass_lo) begin
          pass_lo_reg <= wr_data_i;
        end
        if (hit_select) begin
          select_reg <= wr_data_i & `SBC_SEL_MASK;
        end
        if (hit_confirm) begin
          confirm_reg <= wr_data_i & `SBC_SEL_MASK;
        end
      end
    end
  end

  // Command pulses; trip wins if open and close are both requested
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_ack_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      timeout_o <= 1'b0;
      latch_reset_global_o <= 1'b0;
      maintenance_schedule_alarm_o <= 1'b0;
      runtime_alarm_o <= 1'b0;
      wear_alarm_o <= 1'b0;
      motor_breaker_object_open_o <= 1'b0;
      motor_breaker_object_close_o <= 1'b0;
    end else begin
      cmd_ack_o <= fire && valid_cmd;
      cmd_reject_o <= fire && !valid_cmd;
      timeout_o <= wd_expire && (state_reg == ST_ARMED) && !fire && !wd_restart;
      latch_reset_global_o <= fire && act && select_eff[`SBC_BIT_LATCH_RST];
      maintenance_schedule_alarm_o <= fire && act && select_eff[`SBC_BIT_MAINT_ACK];
      runtime_alarm_o <= fire && act && select_eff[`SBC_BIT_RUNTIME_ACK];
      wear_alarm_o <= fire && act && select_eff[`SBC_BIT_WEAR_ACK];
      motor_breaker_object_open_o <= fire && act && select_eff[`SBC_BIT_OPEN];
      motor_breaker_object_close_o <= fire && act && select_eff[`SBC_BIT_CLOSE]
        && !select_eff[`SBC_BIT_OPEN];
    end
  end

  // Readback: write-only and reserved words read as zero
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= `SBC_WORD_RESET;
      rd_valid_o <= 1'b0;
      armed_o <= 1'b0;
      remote_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      armed_o <= (state_next == ST_ARMED);
      remote_o <= remote_level;
      if (rd_en_i) begin
        if (rd_addr_i == `SBC_ADDR_SELECT) begin
          rd_data_o <= select_reg;
        end else if (rd_addr_i == `SBC_ADDR_CONFIRM) begin
          rd_data_o <= confirm_reg;
        end else begin
          rd_data_o <= `SBC_WORD_RESET;
        end
      end
    end
  end

  wire unused_running = wd_running;
endmodule // sbc_top

// >>> tb/sbc_props.sv
// Port level checks of the staged breaker control block
`timescale 1ns/1ps
module sbc_props #(
  parameter int WATCHDOG_CYCLES = 50
) (
  input logic sys_clk_i,
  input logic rstn_i,
  input logic wr_en_i,
  input logic wr_last_i,
  input logic cmd_ack_o,
  input logic cmd_reject_o,
  input logic timeout_o,
  input logic armed_o,
  input logic remote_o,
  input logic latch_reset_global_o,
  input logic motor_breaker_object_open_o,
  input logic motor_breaker_object_close_o
);
  logic [31:0] idle_cnt;
  wire act = latch_reset_global_o | motor_breaker_object_open_o | motor_breaker_object_close_o;
  // Cycles since the last write word, the watchdog restart point
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) idle_cnt <= 32'h0000_0000;
    else idle_cnt <= wr_en_i ? 32'h0000_0000 : idle_cnt + 32'h0000_0001;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  fire_cause_a: assert property (
    $rose(cmd_ack_o | cmd_reject_o) |-> $past(wr_en_i & wr_last_i)) else $error("verdict no write");
  verdict_excl_a: assert property (
    !(cmd_ack_o & cmd_reject_o)) else $error("ack with reject");
  wdog_span_a: assert property (timeout_o |->
    idle_cnt + 3 >= WATCHDOG_CYCLES && idle_cnt <= WATCHDOG_CYCLES + 3) else $error("bad expiry");
  expiry_disarm_a: assert property (
    timeout_o |-> ##[0:1] !armed_o) else $error("armed after expiry");
  local_quiet_a: assert property (
    act |-> cmd_ack_o && remote_o) else $error("action without remote ack");
  latch_pulse_a: assert property (
    latch_reset_global_o |=> !latch_reset_global_o) else $error("latch pulse too long");
  trip_pulse_a: assert property (
    motor_breaker_object_open_o |=> !motor_breaker_object_open_o) else $error("trip pulse long");
  trip_wins_a: assert property (
    !(motor_breaker_object_open_o & motor_breaker_object_close_o)) else $error("open and close");
  ack_disarm_a: assert property (
    cmd_ack_o |-> !armed_o) else $error("armed after execute");
endmodule // sbc_props
bind sbc_top sbc_props #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) u_props (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i), .wr_last_i(wr_last_i),
  .cmd_ack_o(cmd_ack_o), .cmd_reject_o(cmd_reject_o), .timeout_o(timeout_o),
  .armed_o(armed_o), .remote_o(remote_o), .latch_reset_global_o(latch_reset_global_o),
  .motor_breaker_object_open_o(motor_breaker_object_open_o),
  .motor_breaker_object_close_o(motor_breaker_object_close_o));

// >>> tb/sbc_host_model.sv
// Network host model that stages and fires control commands
`timescale 1ns/1ps
module sbc_host_model (
  input logic sys_clk_i,
  output logic wr_en_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic wr_last_o,
  output logic rd_en_o,
  output logic [15:0] rd_addr_o
);
  initial begin
    {wr_en_o, wr_last_o, rd_en_o} = 3'b000;
    {wr_addr_o, wr_data_o, rd_addr_o} = 48'h0000_0000_0000;
  end
  // Released lines show the inverse so a stale value is never mistaken for data
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic l);
    @(posedge sys_clk_i);
    {wr_en_o, wr_addr_o, wr_data_o, wr_last_o} <= {1'b1, a, d, l};
    @(posedge sys_clk_i);
    {wr_en_o, wr_addr_o, wr_data_o, wr_last_o} <= {1'b0, ~a, ~d, ~l};
  endtask
  // Password high, low, selection, confirm as single writes; the reserved slot is skipped
  task automatic stage(input logic [15:0] sel, input logic [15:0] conf,
    input logic [15:0] pw);
    logic [63:0] w;
    w = {pw, pw, sel, conf};
    for (int k = 0; k < 4; k++) wr(16'hac47 + 16'(k + k / 2), w[63 - 16 * k -: 16], 1'b1);
  endtask
  task automatic fire(input logic [15:0] v);
    wr(16'hac46, v, 1'b1);
  endtask
  task automatic txn(input logic [15:0] sel);
    logic [95:0] w;
    w = {16'h0001, 16'h2020, 16'h2020, 16'h0000, sel, sel};
    for (int k = 0; k < 6; k++) wr(16'hac46 + 16'(k), w[95 - 16 * k -: 16], k == 5);
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk_i);
    {rd_en_o, rd_addr_o} <= {1'b1, a};
    @(posedge sys_clk_i);
    {rd_en_o, rd_addr_o} <= {1'b0, ~a};
  endtask
endmodule // sbc_host_model

// >>> tb/sbc_top_tb_top.sv
// Self-checking bench of the staged breaker control block
`timescale 1ns/1ps
module sbc_top_tb_top;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic remote_mode_i = 1'b1;
  logic wr_en, wr_last, rd_en;
  logic [15:0] wr_addr, wr_data, rd_addr;
  wire [15:0] rd_data;
  wire [5:0] act;
  wire rd_valid, ack, rej, tmo, armed, remote;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sbc_host_model u_host (.sys_clk_i(sys_clk_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_last_o(wr_last), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  sbc_top #(.WATCHDOG_CYCLES(30'd50)) i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_last_i(wr_last),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .remote_mode_i(remote_mode_i), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .cmd_ack_o(ack), .cmd_reject_o(rej), .timeout_o(tmo),
    .armed_o(armed), .remote_o(remote), .latch_reset_global_o(act[5]),
    .maintenance_schedule_alarm_o(act[4]), .runtime_alarm_o(act[3]), .wear_alarm_o(act[2]),
    .motor_breaker_object_open_o(act[1]), .motor_breaker_object_close_o(act[0]));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    u_host.rd(a);
    #1 chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask
  task automatic s_actions;
    logic [15:0] sel;
    for (int i = 2; i < 9; i++) begin
      sel = (i == 8) ? 16'h000c : (16'h0001 << i);
      u_host.stage(sel, sel, 16'h2020);
      #1 chk({15'h0000, armed}, 16'h0001);
      u_host.fire(16'h0001);
      // Open and close together: the trip is the safe one to keep
      #1 chk({armed, ack, act}, {2'b01, (i == 8) ? 6'b000010 : sel[7:2]});
      rd_chk(16'hac4a, 16'h0000);
    end
  endtask
  task automatic s_bad_exec;
    u_host.stage(16'h0008, 16'h0004, 16'h2020);
    u_host.fire(16'h0001);
    #1 chk({ack, rej, act}, 8'h40);
    rd_chk(16'hac4a, 16'h0000);
    u_host.stage(16'h0008, 16'h0008, 16'h2021);
    u_host.fire(16'h0001);
    #1 chk({ack, rej, act}, 8'h40);
    u_host.stage(16'h0008, 16'h0008, 16'h2020);
    rd_chk(16'hac47, 16'h0000);
    u_host.fire(16'h0002);
    #1 chk({ack, rej, act}, 8'h00);
    rd_chk(16'hac4a, 16'h0008);
    u_host.fire(16'h0001);
    #1 chk({ack, act}, 7'h42);
  endtask
  task automatic s_local;
    @(posedge sys_clk_i) remote_mode_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    u_host.stage(16'h00fc, 16'h00fc, 16'h2020);
    u_host.fire(16'h0001);
    #1 chk({remote, ack, act}, 8'h40);
    @(posedge sys_clk_i) remote_mode_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic s_timeout;
    u_host.stage(16'h0080, 16'h0080, 16'h2020);
    for (int k = 0; k < 200 && tmo !== 1'b1; k++) @(posedge sys_clk_i) #1;
    chk({armed, tmo}, 2'b01);
    rd_chk(16'hac4b, 16'h0000);
    u_host.fire(16'h0001);
    #1 chk({ack, rej, act}, 8'h40);
  endtask
  task automatic s_txn;
    u_host.txn(16'h0004);
    #1 chk({ack, act}, 7'h41);
    rd_chk(16'hac4b, 16'h0000);
  endtask
  // Reset in mid-run with a staged command: nothing staged may survive it
  task automatic s_reset;
    u_host.stage(16'h0008, 16'h0008, 16'h2020);
    @(posedge sys_clk_i) rstn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 chk({armed, remote, rd_valid, ack}, 4'h0);
    @(posedge sys_clk_i) rstn_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    u_host.fire(16'h0001);
    #1 chk({ack, rej, act}, 8'h40);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    s_actions();
    s_bad_exec();
    s_local();
    s_timeout();
    s_txn();
    s_reset();
    wrap_up();
  end
endmodule // sbc_top_tb_top
